// [core/pst_params.svh]
`ifndef PST_PARAMS_SVH
`define PST_PARAMS_SVH

// ------------------------------------------------------------
// Program store sizing
// ------------------------------------------------------------
`define PST_MAX_PROG     11'h7D0
`define PST_MAX_ENTRY    16'h9C40
`define PST_TEXT_W       32

// ------------------------------------------------------------
// Channel number ranges
// ------------------------------------------------------------
`define PST_CH_LO_MIN    11'h001
`define PST_CH_LO_MAX    11'h00A
`define PST_CH_HI_MIN    11'h065
`define PST_CH_HI_MAX    11'h3EA
`define PST_CH_PER_SLOT  11'h064
`define PST_NUM_UNITS    10
`define PST_PAT_W        8

// ------------------------------------------------------------
// Reset values and response characters
// ------------------------------------------------------------
`define PST_TRIG_RESET   2'h0
`define PST_TRIG_MAX     8'h03
`define PST_ASCII_ZERO   8'h30
`define PST_ASCII_CR     8'h0D
`define PST_ASCII_LF     8'h0A

`endif

// [core/pst_pkg.sv]
package pst_pkg;

  // ----------------------------------------------------------
  // Decoded host commands
  // ----------------------------------------------------------
  typedef enum logic [2:0] {
    pst_cmd_other        = 3'h0,
    pst_cmd_begin        = 3'h1,
    pst_cmd_end          = 3'h2,
    pst_cmd_exec_a       = 3'h3,
    pst_cmd_launch_b     = 3'h4,
    pst_cmd_cond_query   = 3'h5,
    pst_cmd_trig_select  = 3'h6,
    pst_cmd_trig_query   = 3'h7
  } pst_cmd_type;

  // ----------------------------------------------------------
  // Response formatter states
  // ----------------------------------------------------------
  typedef enum logic [2:0] {
    pst_fmt_idle = 3'h0,
    pst_fmt_hund = 3'h1,
    pst_fmt_tens = 3'h2,
    pst_fmt_ones = 3'h3,
    pst_fmt_cr   = 3'h4,
    pst_fmt_lf   = 3'h5
  } pst_fmt_type;

  // ----------------------------------------------------------
  // Trigger output modes
  // ----------------------------------------------------------
  typedef enum logic [1:0] {
    pst_trig_off    = 2'h0,
    pst_trig_pulse  = 2'h1,
    pst_trig_change = 2'h2,
    pst_trig_every  = 2'h3
  } pst_trig_type;

endpackage

// [core/pst_dec_fmt.sv]
`timescale 1ns/100ps
`include "pst_params.svh"

// Sends an 8-bit value as decimal text, then CR and LF with EOI on LF.
module pst_dec_fmt (
  input  wire logic       i_core_clk,
  input  wire logic       i_reset,
  input  wire logic       i_start,
  input  wire logic [7:0] i_value,
  output logic            o_busy,
  output logic            o_char_valid,
  output logic [7:0]      o_char,
  output logic            o_eoi
);

  // ----------------------------------------------------------
  // Digit capture and sequencing
  // ----------------------------------------------------------
  pst_pkg::pst_fmt_type state;   // Current emit step
  logic [3:0]           d_hund;  // Hundreds digit
  logic [3:0]           d_tens;  // Tens digit
  logic [3:0]           d_ones;  // Ones digit

  // Splits the value and walks through the characters
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      state <= pst_pkg::pst_fmt_idle;
      d_hund <= 4'h0;
      d_tens <= 4'h0;
      d_ones <= 4'h0;
    end else begin
      case (state)
        pst_pkg::pst_fmt_idle: begin
          if (i_start) begin
            d_hund <= 4'(i_value / 8'h64);
            d_tens <= 4'((i_value / 8'h0A) % 8'h0A);
            d_ones <= 4'(i_value % 8'h0A);
            // Leading zeros are suppressed
            if (i_value >= 8'h64) begin
              state <= pst_pkg::pst_fmt_hund;
            end else if (i_value >= 8'h0A) begin
              state <= pst_pkg::pst_fmt_tens;
            end else begin
              state <= pst_pkg::pst_fmt_ones;
            end
          end
        end
        pst_pkg::pst_fmt_hund: state <= pst_pkg::pst_fmt_tens;
        pst_pkg::pst_fmt_tens: state <= pst_pkg::pst_fmt_ones;
        pst_pkg::pst_fmt_ones: state <= pst_pkg::pst_fmt_cr;
        pst_pkg::pst_fmt_cr:   state <= pst_pkg::pst_fmt_lf;
        default:               state <= pst_pkg::pst_fmt_idle;
      endcase
    end
  end

  // ----------------------------------------------------------
  // Registered character outputs
  // ----------------------------------------------------------
  // One character per cycle, EOI only with the line feed
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_char_valid <= 1'b0;
      o_char <= 8'h00;
      o_eoi <= 1'b0;
      o_busy <= 1'b0;
    end else begin
      o_char_valid <= (state != pst_pkg::pst_fmt_idle);
      o_eoi <= (state == pst_pkg::pst_fmt_lf);
      o_busy <= (state != pst_pkg::pst_fmt_idle) || i_start;
      case (state)
        pst_pkg::pst_fmt_hund: o_char <= `PST_ASCII_ZERO + {4'h0, d_hund};
        pst_pkg::pst_fmt_tens: o_char <= `PST_ASCII_ZERO + {4'h0, d_tens};
        pst_pkg::pst_fmt_ones: o_char <= `PST_ASCII_ZERO + {4'h0, d_ones};
        pst_pkg::pst_fmt_cr:   o_char <= `PST_ASCII_CR;
        pst_pkg::pst_fmt_lf:   o_char <= `PST_ASCII_LF;
        default:               o_char <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  sequence s_cr_out;
    o_char_valid && (o_char == `PST_ASCII_CR) && !o_eoi;
  endsequence

  sequence s_lf_out;
    o_char_valid && (o_char == `PST_ASCII_LF) && o_eoi;
  endsequence

  property p_term_pair;
    @(posedge i_core_clk) disable iff (i_reset)
      s_cr_out |=> s_lf_out ##1 !o_char_valid;
  endproperty
  a_term_pair: assert property (p_term_pair)
    else $error("CR not followed by LF with EOI");

  property p_start_ends;
    @(posedge i_core_clk) disable iff (i_reset)
      (state == pst_pkg::pst_fmt_idle) && i_start |-> ##[3:6] s_lf_out;
  endproperty
  a_start_ends: assert property (p_start_ends)
    else $error("Response not terminated in time");

endmodule

// [core/pst_core.sv]
`timescale 1ns/100ps
`include "pst_params.svh"

module pst_core (
  input  wire logic                                   i_core_clk,
  input  wire logic                                   i_reset,
  input  wire logic                                   i_cmd_valid,
  input  wire pst_pkg::pst_cmd_type                   i_cmd_code,
  input  wire logic [10:0]                            i_cmd_arg,
  input  wire logic [7:0]                             i_cmd_state,
  input  wire logic [`PST_TEXT_W-1:0]                 i_cmd_text,
  input  wire logic [7:0]                             i_status_byte,
  input  wire logic [`PST_NUM_UNITS-1:0]              i_pulse,
  input  wire logic [`PST_NUM_UNITS-1:0]              i_seq_start,
  input  wire logic [`PST_NUM_UNITS-1:0]              i_pat_start,
  input  wire logic [`PST_NUM_UNITS*`PST_PAT_W-1:0]   i_pat_id,
  output logic                                        o_resp_valid,
  output logic [7:0]                                  o_resp_char,
  output logic                                        o_resp_eoi,
  output logic                                        o_resp_busy,
  output logic                                        o_exec_valid,
  output logic                                        o_exec_launch,
  output logic [15:0]                                 o_exec_base,
  output logic [15:0]                                 o_exec_len,
  output logic                                        o_recording,
  output logic                                        o_mem_full,
  output logic                                        o_param_error,
  output logic [`PST_NUM_UNITS-1:0]                   o_trig
);

  // ----------------------------------------------------------
  // Program storage
  // ----------------------------------------------------------
  logic [`PST_TEXT_W-1:0] prog_mem [0:`PST_MAX_ENTRY-1]; // Command text
  logic [15:0] dir_base [1:`PST_MAX_PROG];   // First entry per program
  logic [15:0] dir_len  [1:`PST_MAX_PROG];   // Entry count per program
  logic [`PST_MAX_PROG:1] prog_valid;        // Program present flags
  logic [15:0] wr_ptr;                       // Next free entry
  logic [15:0] rec_base;                     // Start of open program
  logic [15:0] rec_len;                      // Entries so far
  logic [10:0] rec_prog;                     // Index being recorded

  // ----------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------
  logic        is_cmd;       // Command arrives this cycle while not recording
  logic        idx_ok;       // Program index within range
  logic        rec_store;    // Store the command as program text
  logic        rec_close;    // Close the open program
  logic [15:0] close_len;    // Length written at close
  logic        begin_ok;     // Start a new recording
  logic        exec_req;     // One of the two execute commands
  logic        exec_ok;      // Execute a present program
  logic        ch_ok;        // Channel number in range
  logic [3:0]  ch_unit;      // Unit addressed by channel
  logic        sel_ok;       // Accepted mode selection
  logic        query_take;   // Query handed to the formatter
  logic [7:0]  query_value;  // Value to answer with
  logic        next_param_error;

  assign is_cmd   = i_cmd_valid && !o_recording;
  assign idx_ok   = (i_cmd_arg >= 11'h001) &&
                    (i_cmd_arg <= `PST_MAX_PROG);
  assign begin_ok = is_cmd && (i_cmd_code == pst_pkg::pst_cmd_begin) &&
                    idx_ok;
  // While recording with memory not full every command except end is only stored
  assign rec_store = o_recording && i_cmd_valid && !o_mem_full &&
                     (i_cmd_code != pst_pkg::pst_cmd_end);
  assign rec_close = o_recording && ((i_cmd_valid &&
                     (i_cmd_code == pst_pkg::pst_cmd_end)) ||
                     (rec_store &&
                      (wr_ptr == `PST_MAX_ENTRY - 16'h0001)) ||
                     o_mem_full);
  assign close_len = rec_store ? rec_len + 16'h0001 : rec_len;
  assign exec_req  = is_cmd &&
                     ((i_cmd_code == pst_pkg::pst_cmd_exec_a) ||
                      (i_cmd_code == pst_pkg::pst_cmd_launch_b));
  assign exec_ok   = exec_req && idx_ok && prog_valid[i_cmd_arg];

  // Channel to unit: 1..10 direct, 101..1002 by hundreds
  always_comb begin
    ch_ok = 1'b0;
    ch_unit = 4'h0;
    if ((i_cmd_arg >= `PST_CH_LO_MIN) &&
        (i_cmd_arg <= `PST_CH_LO_MAX)) begin
      ch_ok = 1'b1;
      ch_unit = 4'(i_cmd_arg - 11'h001);
    end else if ((i_cmd_arg >= `PST_CH_HI_MIN) &&
                 (i_cmd_arg <= `PST_CH_HI_MAX)) begin
      ch_ok = 1'b1;
      ch_unit = 4'((i_cmd_arg / `PST_CH_PER_SLOT) - 11'h001);
    end
  end

  assign sel_ok = is_cmd && (i_cmd_code == pst_pkg::pst_cmd_trig_select)
                  && ch_ok && (i_cmd_state <= `PST_TRIG_MAX);

  // ----------------------------------------------------------
  // Recording control
  // ----------------------------------------------------------
  // Opens, fills and closes one program at a time
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_recording <= 1'b0;
      rec_base <= 16'h0000;
      rec_len <= 16'h0000;
      rec_prog <= 11'h000;
      wr_ptr <= 16'h0000;
      o_mem_full <= 1'b0;
    end else begin
      if (begin_ok) begin
        o_recording <= 1'b1;
        rec_base <= wr_ptr;
        rec_len <= 16'h0000;
        rec_prog <= i_cmd_arg;
      end else if (rec_close) begin
        o_recording <= 1'b0;
      end
      if (rec_store) begin
        wr_ptr <= wr_ptr + 16'h0001;
        rec_len <= rec_len + 16'h0001;
        o_mem_full <= (wr_ptr == `PST_MAX_ENTRY - 16'h0001);
      end
    end
  end

  // Program text lands in the next free entry
  always_ff @(posedge i_core_clk) begin
    if (rec_store) begin
      prog_mem[wr_ptr] <= i_cmd_text;
    end
  end

  // Directory entry is written when the program closes
  always_ff @(posedge i_core_clk) begin
    if (rec_close) begin
      dir_base[rec_prog] <= rec_base;
      dir_len[rec_prog] <= close_len;
    end
  end

  // Presence flags: cleared at begin so the old program is dropped
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      prog_valid <= '0;
    end else if (begin_ok) begin
      prog_valid[i_cmd_arg] <= 1'b0;
    end else if (rec_close) begin
      prog_valid[rec_prog] <= 1'b1;
    end
  end

  // ----------------------------------------------------------
  // Execution requests
  // ----------------------------------------------------------
  // Hands base and length of a stored program to the runner
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_exec_valid <= 1'b0;
      o_exec_launch <= 1'b0;
      o_exec_base <= 16'h0000;
      o_exec_len <= 16'h0000;
    end else begin
      o_exec_valid <= exec_ok;
      if (exec_ok) begin
        o_exec_launch <= (i_cmd_code == pst_pkg::pst_cmd_launch_b);
        o_exec_base <= dir_base[i_cmd_arg];
        o_exec_len <= dir_len[i_cmd_arg];
      end
    end
  end

  // ----------------------------------------------------------
  // Trigger mode per unit
  // ----------------------------------------------------------
  pst_pkg::pst_trig_type trig_mode [0:`PST_NUM_UNITS-1]; // Unit modes

  genvar gu;
  generate
    for (gu = 0; gu < `PST_NUM_UNITS; gu = gu + 1) begin : g_unit
      logic [`PST_PAT_W-1:0] last_id;  // Pattern last started
      logic                  seen;     // A pattern started already
      logic [`PST_PAT_W-1:0] cur_id;   // Pattern starting now

      assign cur_id = i_pat_id[gu*`PST_PAT_W +: `PST_PAT_W];

      // Any channel of the unit sets the common mode
      always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
          trig_mode[gu] <= pst_pkg::pst_trig_type'(`PST_TRIG_RESET);
        end else if (sel_ok && (ch_unit == 4'(gu))) begin
          trig_mode[gu] <= pst_pkg::pst_trig_type'(i_cmd_state[1:0]);
        end
      end

      // Tracks pattern identity for change detection
      always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
          last_id <= '0;
          seen <= 1'b0;
        end else if (i_pat_start[gu]) begin
          last_id <= cur_id;
          seen <= 1'b1;
        end else if (i_seq_start[gu]) begin
          seen <= 1'b0;
        end
      end

      // Trigger pulse by mode
      always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
          o_trig[gu] <= 1'b0;
        end else begin
          case (trig_mode[gu])
            pst_pkg::pst_trig_off: begin
              o_trig[gu] <= 1'b0;
            end
            pst_pkg::pst_trig_pulse: begin
              o_trig[gu] <= i_pulse[gu] || i_seq_start[gu];
            end
            pst_pkg::pst_trig_change: begin
              o_trig[gu] <= i_pat_start[gu] &&
                            (!seen || (cur_id != last_id));
            end
            default: begin
              o_trig[gu] <= i_pat_start[gu];
            end
          endcase
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------
  // Queries and parameter errors
  // ----------------------------------------------------------
  // Status byte is only read here, never cleared
  always_comb begin
    query_take = 1'b0;
    query_value = i_status_byte;
    if (is_cmd && !o_resp_busy) begin
      if (i_cmd_code == pst_pkg::pst_cmd_cond_query) begin
        query_take = 1'b1;
      end else if ((i_cmd_code == pst_pkg::pst_cmd_trig_query) &&
                   ch_ok) begin
        query_take = 1'b1;
        query_value = {6'h00, trig_mode[ch_unit]};
      end
    end
  end

  always_comb begin
    next_param_error = 1'b0;
    if (is_cmd) begin
      if ((i_cmd_code == pst_pkg::pst_cmd_begin) && !idx_ok) begin
        next_param_error = 1'b1;
      end else if (exec_req && !exec_ok) begin
        next_param_error = 1'b1;
      end else if ((i_cmd_code == pst_pkg::pst_cmd_trig_select) &&
                   !sel_ok) begin
        next_param_error = 1'b1;
      end else if ((i_cmd_code == pst_pkg::pst_cmd_trig_query) &&
                   !ch_ok) begin
        next_param_error = 1'b1;
      end
    end
  end

  // Error flag pulses one cycle per rejected command
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_param_error <= 1'b0;
    end else begin
      o_param_error <= next_param_error;
    end
  end

  // Decimal text with CR LF and EOI
  pst_dec_fmt u_fmt (
    .i_core_clk   (i_core_clk),
    .i_reset      (i_reset),
    .i_start      (query_take),
    .i_value      (query_value),
    .o_busy       (o_resp_busy),
    .o_char_valid (o_resp_valid),
    .o_char       (o_resp_char),
    .o_eoi        (o_resp_eoi)
  );

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  property p_bad_begin;
    @(posedge i_core_clk) disable iff (i_reset)
      is_cmd && (i_cmd_code == pst_pkg::pst_cmd_begin) && !idx_ok
      |=> o_param_error && !o_recording;
  endproperty
  a_bad_begin: assert property (p_bad_begin)
    else $error("Invalid program index accepted");

  property p_store_adv;
    @(posedge i_core_clk) disable iff (i_reset)
      rec_store |=> (wr_ptr == $past(wr_ptr) + 16'h0001);
  endproperty
  a_store_adv: assert property (p_store_adv)
    else $error("Recorded command not stored");

  property p_no_run;
    @(posedge i_core_clk) disable iff (i_reset)
      o_recording && i_cmd_valid |=> !o_exec_valid;
  endproperty
  a_no_run: assert property (p_no_run)
    else $error("Program ran while recording");

  property p_sel_keep;
    @(posedge i_core_clk) disable iff (i_reset)
      is_cmd && (i_cmd_code == pst_pkg::pst_cmd_trig_select) &&
      (i_cmd_state > `PST_TRIG_MAX)
      |=> o_param_error && $stable(trig_mode[0]);
  endproperty
  a_sel_keep: assert property (p_sel_keep)
    else $error("Bad trigger mode changed setting");

  property p_sel_unit;
    @(posedge i_core_clk) disable iff (i_reset)
      sel_ok && (ch_unit == 4'h0)
      |=> (trig_mode[0] == $past(i_cmd_state[1:0]));
  endproperty
  a_sel_unit: assert property (p_sel_unit)
    else $error("Unit mode not updated");

  property p_off_quiet;
    @(posedge i_core_clk) disable iff (i_reset)
      (trig_mode[0] == pst_pkg::pst_trig_off) ##1
      (trig_mode[0] == pst_pkg::pst_trig_off) |-> !o_trig[0];
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("Trigger while disabled");

  property p_pulse_trig;
    @(posedge i_core_clk) disable iff (i_reset)
      (trig_mode[0] == pst_pkg::pst_trig_pulse) && i_pulse[0] |=> o_trig[0];
  endproperty
  a_pulse_trig: assert property (p_pulse_trig)
    else $error("Missing pulse trigger");

  property p_change_trig;
    @(posedge i_core_clk) disable iff (i_reset)
      (trig_mode[0] == pst_pkg::pst_trig_change) && i_pat_start[0] &&
      g_unit[0].seen && (g_unit[0].cur_id == g_unit[0].last_id)
      |=> !o_trig[0];
  endproperty
  a_change_trig: assert property (p_change_trig)
    else $error("Trigger on repeated pattern");

  property p_every_trig;
    @(posedge i_core_clk) disable iff (i_reset)
      (trig_mode[0] == pst_pkg::pst_trig_every) && i_pat_start[0]
      |=> o_trig[0];
  endproperty
  a_every_trig: assert property (p_every_trig)
    else $error("Missing pattern trigger");

  property p_query_resp;
    @(posedge i_core_clk) disable iff (i_reset)
      query_take |=> o_resp_busy ##[1:4] o_resp_valid;
  endproperty
  a_query_resp: assert property (p_query_resp)
    else $error("Query not answered");

endmodule

// [verif/pst_host.sv]
`timescale 1ns/100ps
// Host model: issues commands, gathers a decimal answer
module pst_host (
  input  wire logic            i_core_clk,
  input  wire logic            i_resp_valid,
  input  wire logic [7:0]      i_resp_char,
  input  wire logic            i_resp_eoi,
  output logic                 o_cmd_valid,
  output pst_pkg::pst_cmd_type o_cmd_code,
  output logic [10:0]          o_cmd_arg,
  output logic [7:0]           o_cmd_state,
  output logic [31:0]          o_cmd_text,
  output logic [9:0]           o_value,
  output logic                 o_done
);
  logic [7:0] last_char;  // Previous answer character
  initial begin
    {o_cmd_valid, o_cmd_arg, o_cmd_state, o_cmd_text} = '0;
    o_cmd_code = pst_pkg::pst_cmd_other;
  end
  // One command, held for one edge, then arg and state lines show the inverse
  task automatic send(input pst_pkg::pst_cmd_type c, input logic [10:0] a,
                      input logic [7:0] s);
    @(posedge i_core_clk) #1;
    o_cmd_valid = 1'b1;
    o_cmd_code  = c;
    o_cmd_arg   = a;
    o_cmd_state = s;
    o_cmd_text  = {21'h000000, a};
    @(posedge i_core_clk) #1;
    o_cmd_valid = 1'b0;
    o_cmd_arg   = ~a;
    o_cmd_state = ~s;
  endtask
  // Each command clears the answer; digits accumulate; done only
  // for CR then LF with EOI
  always @(posedge i_core_clk) begin
    if (o_cmd_valid === 1'b1) begin
      o_value   <= '0;
      o_done    <= 1'b0;
      last_char <= '0;
    end else if (i_resp_valid === 1'b1) begin
      last_char <= i_resp_char;
      if (i_resp_char >= 8'h30 && i_resp_char <= 8'h39)
        o_value <= o_value * 10'h00A + {2'h0, i_resp_char - 8'h30};
      if (i_resp_eoi === 1'b1)
        o_done <= (i_resp_char === 8'h0A) && (last_char === 8'h0D);
    end
  end
endmodule

// [verif/program_store_and_trigger_select_test.sv]
`timescale 1ns/100ps
module program_store_and_trigger_select_test;
  logic clk, rst, rv, re, by, ev, el, rc, mf, pe;
  logic cv;
  pst_pkg::pst_cmd_type cc;
  logic [10:0] ca;
  logic [7:0]  cs, sb, ch;
  logic [31:0] ct;
  logic [9:0]  pu, ss, ps, tr, val;
  logic [79:0] pid;
  logic [15:0] eb, len;
  logic        dn;
  int bad_count, n_checks, n_err, n_exec, n_trig, k;
  pst_core i_pst_core (.i_core_clk(clk), .i_reset(rst), .i_cmd_valid(cv),
    .i_cmd_code(cc), .i_cmd_arg(ca), .i_cmd_state(cs), .i_cmd_text(ct),
    .i_status_byte(sb), .i_pulse(pu), .i_seq_start(ss), .i_pat_start(ps),
    .i_pat_id(pid), .o_resp_valid(rv), .o_resp_char(ch), .o_resp_eoi(re),
    .o_resp_busy(by), .o_exec_valid(ev), .o_exec_launch(el),
    .o_exec_base(eb), .o_exec_len(len), .o_recording(rc),
    .o_mem_full(mf), .o_param_error(pe), .o_trig(tr));
  pst_host i_pst_host (.i_core_clk(clk), .i_resp_valid(rv),
    .i_resp_char(ch), .i_resp_eoi(re), .o_cmd_valid(cv), .o_cmd_code(cc),
    .o_cmd_arg(ca), .o_cmd_state(cs), .o_cmd_text(ct), .o_value(val),
    .o_done(dn));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Pulse counters for errors, runs and unit 1 triggers
  always @(posedge clk) begin
    n_err  += (pe === 1'b1);
    n_exec += (ev === 1'b1);
    n_trig += (tr[0] === 1'b1);
  end
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // Query, bounded wait for a framed answer, compare its value
  task automatic ask(input pst_pkg::pst_cmd_type c, input logic [10:0] a,
                     input logic [9:0] exp);
    i_pst_host.send(c, a, 8'h00);
    for (k = 0; k < 20 && dn !== 1'b1; k++) @(posedge clk);
    if (dn !== 1'b1) begin
      bad_count++;
      $display("Error at %0t: no framed answer", $time);
      wrap_up();
    end else begin
      check({6'h00, val}, {6'h00, exp});
      check({15'h0, by}, 16'h0000);
    end
  endtask
  // One event pulse on unit 1: 0 pulse, 1 pattern, 2 sequence
  task automatic kick(input int w, input logic [7:0] id);
    @(posedge clk) #1;
    pid[7:0] = id;
    {pu[0], ss[0], ps[0]} = (w == 0) ? 3'h4 : (w == 2) ? 3'h2 : 3'h1;
    @(posedge clk) #1;
    {pu[0], ss[0], ps[0]} = 3'h0;
    repeat (3) @(posedge clk);
  endtask
  task automatic t_status();
    sb = 8'h00;
    ask(pst_pkg::pst_cmd_cond_query, 0, 10'h000);
    #1 sb = 8'h28;
    ask(pst_pkg::pst_cmd_cond_query, 0, 10'h028);
    #1 sb = 8'hFF;
    ask(pst_pkg::pst_cmd_cond_query, 0, 10'h0FF);
    ask(pst_pkg::pst_cmd_cond_query, 0, 10'h0FF);
  endtask
  // Record n entries into program 5 at base b, then run it
  task automatic t_prog(input int n, input pst_pkg::pst_cmd_type run,
                        input logic [15:0] b);
    k = n_exec;
    i_pst_host.send(pst_pkg::pst_cmd_begin, 11'h005, 8'h00);
    check({15'h0, rc}, 16'h0001);
    repeat (n) i_pst_host.send(pst_pkg::pst_cmd_cond_query, 0, 8'h00);
    i_pst_host.send(pst_pkg::pst_cmd_end, 0, 8'h00);
    check({15'h0, rc}, 16'h0000);
    check({15'h0, mf}, 16'h0000);
    check(16'(n_exec - k), 16'h0000);
    i_pst_host.send(run, 11'h005, 8'h00);
    repeat (3) @(posedge clk);
    check(16'(n_exec - k), 16'h0001);
    check(len, 16'(n));
    check(eb, b);
    check({15'h0, el}, {15'h0, run == pst_pkg::pst_cmd_launch_b});
  endtask
  task automatic t_trig();
    ask(pst_pkg::pst_cmd_trig_query, 11'h007, 10'h000);
    k = n_err;
    i_pst_host.send(pst_pkg::pst_cmd_begin, 11'h000, 8'h00);
    i_pst_host.send(pst_pkg::pst_cmd_begin, 11'h7D1, 8'h00);
    i_pst_host.send(pst_pkg::pst_cmd_trig_select, 11'h001, 8'h04);
    i_pst_host.send(pst_pkg::pst_cmd_trig_query, 11'h00B, 8'h00);
    repeat (3) @(posedge clk);
    check(16'(n_err - k), 16'h0004);
    ask(pst_pkg::pst_cmd_trig_query, 11'h001, 10'h000);
    i_pst_host.send(pst_pkg::pst_cmd_trig_select, 11'h065, 8'h03);
    ask(pst_pkg::pst_cmd_trig_query, 11'h001, 10'h003);
    k = n_trig;
    kick(1, 8'h05);
    kick(1, 8'h05);
    kick(0, 8'h00);
    check(16'(n_trig - k), 16'h0002);
    i_pst_host.send(pst_pkg::pst_cmd_trig_select, 11'h001, 8'h01);
    k = n_trig;
    kick(0, 8'h00);
    kick(1, 8'h05);
    kick(2, 8'h00);
    check(16'(n_trig - k), 16'h0002);
    i_pst_host.send(pst_pkg::pst_cmd_trig_select, 11'h001, 8'h02);
    k = n_trig;
    kick(2, 8'h00);
    kick(1, 8'h05);
    kick(1, 8'h05);
    kick(1, 8'h06);
    check(16'(n_trig - k), 16'h0002);
  endtask
  initial begin
    {bad_count, n_checks, n_err, n_exec, n_trig} = '0;
    {sb, pu, ss, ps, pid} = '0;
    rst = 1'b1;
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    t_status();
    t_prog(1, pst_pkg::pst_cmd_exec_a, 16'h0000);
    t_prog(2, pst_pkg::pst_cmd_launch_b, 16'h0001);
    t_trig();
    wrap_up();
  end
endmodule
